// File: sti_cond_check.sv
`timescale 1ns/100ps
module sti_cond_check (
	input wire logic [3:0] cond,
	input wire logic [3:0] flags,
	output logic pass
);
	logic n;
	logic z;
	logic c;
	logic v;
	logic base;

	assign {n, z, c, v} = flags;

	// Even codes test, odd codes invert
	always_comb begin
		case (cond[3:1])
			3'h0: base = z;
			3'h1: base = c;
			3'h2: base = n;
			3'h3: base = v;
			3'h4: base = c & ~z;
			3'h5: base = (n == v);
			3'h6: base = ~z & (n == v);
			default: base = 1'b1;
		endcase
		if (cond == 4'hf) begin
			pass = 1'b0;
		end else begin
			pass = cond[0] ? ~base : base;
		end
	end
endmodule : sti_cond_check

// File: sti_mem_model.sv
`timescale 1ns/100ps
module sti_mem_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mem_req,
	input wire sti_pkg::sti_mem_s mem_out,
	output logic mem_ack,
	output logic mem_abort,
	input wire logic [3:0] wt,
	input wire logic [7:0] ab_at,
	output logic [7:0] nacc_r
);
	sti_pkg::sti_mem_s lg [0:255];
	logic [3:0] cnt_r;
	logic tog_r;
	logic deny;
	// User-flagged access to upper half refused
	assign deny = mem_out.user & mem_out.addr[31];
	assign mem_ack = mem_req & (cnt_r == wt);
	// Abort line meaningless without ack
	assign mem_abort = mem_ack ? (deny | (nacc_r == ab_at)) : tog_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 4'h0;
		end else if (mem_ack || !mem_req) begin
			cnt_r <= 4'h0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tog_r <= 1'h0;
		end else begin
			tog_r <= ~tog_r;
		end
	end
	// Access log
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nacc_r <= 8'h0;
		end else if (mem_ack) begin
			lg[nacc_r] <= mem_out;
			nacc_r <= nacc_r + 8'h1;
		end
	end
endmodule : sti_mem_model

// File: sti_pkg.sv
package sti_pkg;
	// Register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_COUNT = 8'h08;
	// Control and status fields
	localparam int CTRL_ALIGN_BIT = 0;
	localparam logic CTRL_ALIGN_RST = 1'h0;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_ALIGN_BIT = 1;
	localparam int ST_ABORT_BIT = 2;
	// Instruction fields
	localparam int B_I = 25;
	localparam int B_P = 24;
	localparam int B_U = 23;
	localparam int B_S = 22;
	localparam int B_W = 21;
	localparam int B_L = 20;
	localparam logic [2:0] OP_MULTI = 3'h4;
	localparam logic [1:0] OP_SINGLE = 2'h1;
	localparam logic [3:0] PC_IDX = 4'hf;
	localparam logic [31:0] WORD_STEP = 32'h4;
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam logic [4:0] MODE_SYS = 5'h1f;
	localparam logic SCC_PRESENT = 1'h1;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_BASE = 5'h02,
		S_DATA = 5'h04,
		S_MEM = 5'h08,
		S_FIN = 5'h10
	} sti_state_e;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] wdata;
		logic byte_sz;
		logic user;
	} sti_mem_s;

	typedef struct packed {
		logic valid;
		logic [3:0] idx;
		logic [31:0] data;
	} sti_wb_s;
endpackage : sti_pkg

// File: sti_store_unit.sv
`timescale 1ns/100ps
// Behaviour
// - Predicate must pass or instruction skipped
// - Decode user-bank store-multiple form
// - Writeback bit updates base after block, except in the user-bank form or with PC as base
// - Abort leaves original base value
// - Block addresses drop low bits, no rotate
// - Misaligned word store raises alignment exception
// - User-bank form reads user registers
// - Scan mask upward, step address by four
// - Base read from current mode bank
// - User-bank form abort keeps original base
// - Decode word store and its fields
// - Word store writes full 32 bits
// - PC source stores fixed file value
// - Single store abort keeps original base
// - Decode byte store, same field layout
// - Byte store writes low eight bits
// - Translated store marked as user access
// - Lowest register to lowest address
module sti_store_unit (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ins_valid,
	input wire logic [31:0] ins_word,
	input wire logic [31:0] ins_offset,
	input wire logic [3:0] flags,
	input wire logic [4:0] cpu_mode,
	output logic ins_ready,
	output logic ins_done,
	output logic [3:0] rf_rd_idx,
	output logic rf_rd_user,
	input wire logic [31:0] rf_rd_data,
	output logic mem_req,
	output sti_pkg::sti_mem_s mem_out,
	input wire logic mem_ack,
	input wire logic mem_abort,
	output sti_pkg::sti_wb_s wb_out,
	output logic align_exc,
	output logic abort_exc
);
	sti_pkg::sti_state_e state_r;
	logic [31:0] ins_r;
	logic [31:0] off_r;
	logic [4:0] mode_r;
	logic [15:0] mask_r;
	logic [31:0] addr_r;
	logic [31:0] wbval_r;
	logic wb_en_r;
	logic ctrl_align_r;
	logic last_align_r;
	logic last_abort_r;
	logic [31:0] count_r;
	logic cond_pass;
	logic dec_multi;
	logic dec_single;
	logic multi_r;
	logic form2_r;
	logic byte_r;
	logic xlate_r;
	logic [31:0] step_n;
	logic [31:0] single_off;
	logic [31:0] single_addr;
	logic [31:0] multi_start;
	logic [31:0] multi_wb;
	logic [15:0] rest;
	logic misalign;
	logic apb_setup;
	logic apb_write;

	function automatic logic [4:0] ones(input logic [15:0] m);
		logic [4:0] k;
		k = 5'h00;
		for (int i = 0; i < 16; i++) begin
			k = k + {4'h0, m[i]};
		end
		return k;
	endfunction : ones

	function automatic logic [3:0] lowest(input logic [15:0] m);
		logic [3:0] k;
		k = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (m[i]) begin
				k = 4'(i);
			end
		end
		return k;
	endfunction : lowest

	sti_cond_check u_cond (
		.cond(ins_word[31:28]),
		.flags(flags),
		.pass(cond_pass)
	);

	// Decode of the incoming word
	assign dec_multi = (ins_word[27:25] == sti_pkg::OP_MULTI) &
		~ins_word[sti_pkg::B_L];
	assign dec_single = (ins_word[27:26] == sti_pkg::OP_SINGLE) &
		~ins_word[sti_pkg::B_L];

	// Address arithmetic on the base read this cycle
	assign step_n = {25'h0, ones(ins_r[15:0]), 2'h0};
	assign single_off = ins_r[sti_pkg::B_I] ? off_r : {20'h0, ins_r[11:0]};
	assign single_addr = ins_r[sti_pkg::B_U] ? rf_rd_data + single_off :
		rf_rd_data - single_off;
	always_comb begin
		case ({ins_r[sti_pkg::B_P], ins_r[sti_pkg::B_U]})
			2'h1: multi_start = rf_rd_data;
			2'h3: multi_start = rf_rd_data + sti_pkg::WORD_STEP;
			2'h0: multi_start = rf_rd_data - step_n + sti_pkg::WORD_STEP;
			default: multi_start = rf_rd_data - step_n;
		endcase
	end
	assign multi_wb = ins_r[sti_pkg::B_U] ? rf_rd_data + step_n :
		rf_rd_data - step_n;
	assign rest = mask_r & (mask_r - 16'h0001);
	assign misalign = ~byte_r & ctrl_align_r & sti_pkg::SCC_PRESENT &
		(addr_r[1:0] != 2'h0);

	// Instruction sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= sti_pkg::S_IDLE;
			ins_ready <= 1'b0;
			ins_done <= 1'b0;
			ins_r <= 32'h0;
			off_r <= 32'h0;
			mode_r <= 5'h00;
			multi_r <= 1'b0;
			form2_r <= 1'b0;
			byte_r <= 1'b0;
			xlate_r <= 1'b0;
			mask_r <= 16'h0;
			addr_r <= 32'h0;
			wbval_r <= 32'h0;
			wb_en_r <= 1'b0;
			rf_rd_idx <= 4'h0;
			rf_rd_user <= 1'b0;
			align_exc <= 1'b0;
			abort_exc <= 1'b0;
			wb_out <= '0;
		end else begin
			ins_done <= 1'b0;
			align_exc <= 1'b0;
			abort_exc <= 1'b0;
			wb_out.valid <= 1'b0;
			case (state_r)
				sti_pkg::S_IDLE: begin
					ins_ready <= 1'b1;
					if (ins_valid && ins_ready) begin
						ins_ready <= 1'b0;
						ins_r <= ins_word;
						off_r <= ins_offset;
						mode_r <= cpu_mode;
						multi_r <= dec_multi;
						form2_r <= dec_multi & ins_word[sti_pkg::B_S];
						byte_r <= dec_single & ins_word[sti_pkg::B_S];
						xlate_r <= dec_single & ~ins_word[sti_pkg::B_P] &
							ins_word[sti_pkg::B_W];
						if (cond_pass && (dec_multi || dec_single)) begin
							rf_rd_idx <= ins_word[19:16];
							rf_rd_user <= 1'b0;
							state_r <= sti_pkg::S_BASE;
						end else begin
							state_r <= sti_pkg::S_FIN;
						end
					end
				end
				sti_pkg::S_BASE: begin
					if (multi_r) begin
						addr_r <= multi_start;
						wbval_r <= multi_wb;
						wb_en_r <= ins_r[sti_pkg::B_W] & ~form2_r &
							(ins_r[19:16] != sti_pkg::PC_IDX);
						mask_r <= ins_r[15:0];
						rf_rd_idx <= lowest(ins_r[15:0]);
						rf_rd_user <= form2_r;
						state_r <= (ins_r[15:0] == 16'h0) ? sti_pkg::S_FIN :
							sti_pkg::S_DATA;
					end else begin
						addr_r <= ins_r[sti_pkg::B_P] ? single_addr : rf_rd_data;
						wbval_r <= single_addr;
						wb_en_r <= (~ins_r[sti_pkg::B_P] | ins_r[sti_pkg::B_W]) &
							(ins_r[19:16] != sti_pkg::PC_IDX);
						rf_rd_idx <= ins_r[15:12];
						rf_rd_user <= 1'b0;
						state_r <= sti_pkg::S_DATA;
					end
				end
				sti_pkg::S_DATA: begin
					if (misalign) begin
						align_exc <= 1'b1;
						state_r <= sti_pkg::S_FIN;
					end else begin
						state_r <= sti_pkg::S_MEM;
					end
				end
				sti_pkg::S_MEM: begin
					if (mem_ack) begin
						if (mem_abort) begin
							abort_exc <= 1'b1;
							state_r <= sti_pkg::S_FIN;
						end else if (multi_r && (rest != 16'h0)) begin
							mask_r <= rest;
							addr_r <= addr_r + sti_pkg::WORD_STEP;
							rf_rd_idx <= lowest(rest);
							state_r <= sti_pkg::S_DATA;
						end else begin
							wb_out.valid <= wb_en_r;
							wb_out.idx <= ins_r[19:16];
							wb_out.data <= wbval_r;
							state_r <= sti_pkg::S_FIN;
						end
					end
				end
				sti_pkg::S_FIN: begin
					ins_done <= 1'b1;
					ins_ready <= 1'b1;
					state_r <= sti_pkg::S_IDLE;
				end
				default: begin
					state_r <= sti_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Memory request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_req <= 1'b0;
			mem_out <= '0;
		end else if (state_r == sti_pkg::S_DATA && !misalign) begin
			mem_req <= 1'b1;
			mem_out.addr <= multi_r ? {addr_r[31:2], 2'h0} : addr_r;
			mem_out.wdata <= byte_r ? {24'h0, rf_rd_data[7:0]} :
				rf_rd_data;
			mem_out.byte_sz <= byte_r;
			mem_out.user <= (mode_r == sti_pkg::MODE_USR) | xlate_r;
		end else if (mem_req && mem_ack) begin
			mem_req <= 1'b0;
		end
	end

	// Outcome flags and store count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_align_r <= 1'b0;
			last_abort_r <= 1'b0;
			count_r <= 32'h0;
		end else begin
			if (align_exc) begin
				last_align_r <= 1'b1;
			end else if (state_r == sti_pkg::S_BASE) begin
				last_align_r <= 1'b0;
			end
			if (abort_exc) begin
				last_abort_r <= 1'b1;
			end else if (state_r == sti_pkg::S_BASE) begin
				last_abort_r <= 1'b0;
			end
			if (mem_req && mem_ack && !mem_abort) begin
				count_r <= count_r + 32'h1;
			end
		end
	end

	// APB slave, zero wait states
	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pready & pwrite;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			ctrl_align_r <= sti_pkg::CTRL_ALIGN_RST;
		end else begin
			pready <= 1'b1;
			if (apb_setup) begin
				pslverr <= 1'b0;
				case (paddr)
					sti_pkg::A_CTRL: prdata <= {31'h0, ctrl_align_r};
					sti_pkg::A_STATUS: prdata <= {29'h0, last_abort_r,
						last_align_r, state_r != sti_pkg::S_IDLE};
					sti_pkg::A_COUNT: prdata <= count_r;
					default: begin
						prdata <= 32'h0;
						pslverr <= 1'b1;
					end
				endcase
			end
			if (apb_write && paddr == sti_pkg::A_CTRL) begin
				ctrl_align_r <= pwdata[sti_pkg::CTRL_ALIGN_BIT];
			end
		end
	end

	AST_COND_SKIP: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == sti_pkg::S_IDLE && ins_valid && ins_ready && !cond_pass
		|=> state_r == sti_pkg::S_FIN ##1 ins_done && !mem_req)
		else $error("failed predicate started a store");
	AST_BASE_BANK: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == sti_pkg::S_BASE |-> !rf_rd_user && rf_rd_idx == ins_r[19:16])
		else $error("base not read from current bank");
	AST_USER_BANK: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == sti_pkg::S_DATA && form2_r |-> rf_rd_user)
		else $error("user-bank form read banked copy");
	AST_ABORT_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_ack && mem_abort |=> abort_exc && !wb_out.valid
		##1 !wb_out.valid && ins_done)
		else $error("base written back after abort");
	AST_FORM2_NOWB: assert property (@(posedge pclk) disable iff (!presetn)
		wb_out.valid |-> !form2_r && wb_out.idx != sti_pkg::PC_IDX)
		else $error("forbidden base writeback");
	AST_BLOCK_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && multi_r |-> mem_out.addr[1:0] == 2'h0 && !mem_out.byte_sz)
		else $error("block address not word aligned");
	AST_STEP_FOUR: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && mem_ack && !mem_abort && multi_r && rest != 16'h0
		|=> ##1 mem_req && mem_out.addr == $past(mem_out.addr, 2) + 32'h4)
		else $error("block address did not step by four");
	AST_ALIGN_TRAP: assert property (@(posedge pclk) disable iff (!presetn)
		state_r == sti_pkg::S_DATA && misalign |=> align_exc && !mem_req)
		else $error("misaligned word store not trapped");
	AST_BYTE_LANE: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(mem_req) && byte_r |-> mem_out.wdata[31:8] == 24'h0
		&& mem_out.wdata[7:0] == $past(rf_rd_data[7:0]))
		else $error("byte store carries more than low byte");
	AST_XLATE_USER: assert property (@(posedge pclk) disable iff (!presetn)
		mem_req && xlate_r |-> mem_out.user)
		else $error("translated store not marked user");
endmodule : sti_store_unit

// File: store_instruction_unit_bench.sv
`timescale 1ns/100ps
module store_instruction_unit_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr, ab_at, nacc_r, n0;
	logic [31:0] pwdata, prdata, ins_word, ins_offset, rf_rd_data, rd;
	logic ins_valid, ins_ready, ins_done, rf_rd_user, mem_req;
	logic mem_ack, mem_abort, align_exc, abort_exc, al, ab, er;
	logic [3:0] flags, rf_rd_idx, wt;
	logic [4:0] cpu_mode;
	logic [36:0] wbv;
	sti_pkg::sti_mem_s mem_out;
	sti_pkg::sti_wb_s wb_out;
	int errors, cmp_count;
	sti_store_unit sti_store_unit_i (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.ins_valid, .ins_word, .ins_offset, .flags, .cpu_mode,
		.ins_ready, .ins_done, .rf_rd_idx, .rf_rd_user, .rf_rd_data,
		.mem_req, .mem_out, .mem_ack, .mem_abort, .wb_out, .align_exc,
		.abort_exc);
	sti_mem_model sti_mem_model_i (.pclk, .presetn, .mem_req, .mem_out,
		.mem_ack, .mem_abort, .wt, .ab_at, .nacc_r);
	// Register file: bank in top nibble
	function automatic logic [31:0] rv(input logic [3:0] i, input logic u);
		return {u ? 4'h1 : {i[3], 3'h2}, 20'h0, i, 2'h0, i[1:0]};
	endfunction : rv
	assign rf_rd_data = rv(rf_rd_idx, rf_rd_user);
	function automatic logic [31:0] sw(input logic [3:0] c,
		input logic p, u, b, w, input logic [3:0] rn, rs,
		input logic [11:0] im);
		return {c, 2'h1, 1'h0, p, u, b, w, 1'h0, rn, rs, im};
	endfunction : sw
	function automatic logic [31:0] sm(input logic p, u, s, w,
		input logic [3:0] rn, input logic [15:0] m);
		return {4'he, 3'h4, p, u, s, w, 1'h0, rn, m};
	endfunction : sm
	task automatic end_of_test;
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [65:0] g, e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic tmo;
		errors++;
		$display("BAD %0t got %h exp %h", $time, 1'h0, 1'h1);
		end_of_test;
	endtask : tmo
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (pready) break;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k == 50) tmo;
	endtask : apb
	task automatic run(input logic [31:0] w, input logic [4:0] m);
		int k;
		wbv = '0;
		al = 1'h0;
		ab = 1'h0;
		n0 = nacc_r;
		@(posedge pclk);
		ins_word <= w;
		cpu_mode <= m;
		ins_valid <= 1'h1;
		for (k = 0; k < 200; k++) begin
			@(negedge pclk);
			if (ins_ready) break;
		end
		if (k == 200) tmo;
		@(posedge pclk);
		ins_valid <= 1'h0;
		for (k = 0; k < 200; k++) begin
			@(negedge pclk);
			if (wb_out.valid) wbv = wb_out;
			al |= align_exc;
			ab |= abort_exc;
			if (ins_done) break;
		end
		if (k == 200) tmo;
	endtask : run
	initial begin
		pclk = 1'h0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		ins_valid = 1'h0;
		ins_word = 32'h0;
		ins_offset = 32'h0;
		flags = 4'h0;
		cpu_mode = 5'h13;
		wt = 4'h0;
		ab_at = 8'hff;
		errors = 0;
		cmp_count = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 8'h0c, 32'h0);
		chk({er, rd}, {1'h1, 32'h0});
		for (int j = 0; j < 2; j++) begin
			flags <= j ? 4'hf : 4'h0;
			for (int c = 0; c < 15; c++) begin
				run(sw(4'(c), 1, 1, 0, 0, 4'h4, 4'h3, 12'h0), 5'h13);
				chk(nacc_r - n0, (j ? 16'h6655 : 16'h56aa) >> c & 1);
			end
		end
		run(sw(4'he, 1, 0, 0, 1, 4'h4, 4'hf, 12'h010), 5'h13);
		chk(sti_mem_model_i.lg[n0], {32'h2000_0030, 32'ha000_00f3, 2'h0});
		chk(wbv, {1'h1, 4'h4, 32'h2000_0030});
		run(sw(4'he, 0, 1, 1, 0, 4'h8, 4'h3, 12'h008), 5'h13);
		chk(sti_mem_model_i.lg[n0], {32'ha000_0080, 32'h33, 2'h2});
		chk(wbv, {1'h1, 4'h8, 32'ha000_0088});
		run(sw(4'he, 0, 1, 1, 1, 4'h8, 4'h3, 12'h008), 5'h13);
		chk({sti_mem_model_i.lg[n0].user, ab, wbv[36]}, 3'h6);
		wt <= 4'h3;
		run(sm(1, 0, 0, 1, 4'h5, 16'h0003), 5'h13);
		chk(sti_mem_model_i.lg[n0], {32'h2000_0048, 32'h2000_0000, 2'h0});
		chk(sti_mem_model_i.lg[n0 + 8'h1], {32'h2000_004c, 32'h2000_0011, 2'h0});
		chk(wbv, {1'h1, 4'h5, 32'h2000_0049});
		wt <= 4'h0;
		run(sm(0, 1, 1, 0, 4'h9, 16'h4001), 5'h13);
		chk(sti_mem_model_i.lg[n0], {32'ha000_0090, 32'h1000_0000, 2'h0});
		chk(sti_mem_model_i.lg[n0 + 8'h1], {32'ha000_0094, 32'h1000_00e2, 2'h0});
		ab_at <= nacc_r + 8'h1;
		run(sm(0, 1, 1, 0, 4'h9, 16'h4001), 5'h13);
		chk({ab, wbv[36]}, 2'h2);
		ab_at <= nacc_r + 8'h1;
		run(sm(1, 0, 0, 1, 4'h5, 16'h0003), 5'h13);
		chk({ab, wbv[36]}, 2'h2);
		ab_at <= 8'hff;
		apb(1'h0, 8'h04, 32'h0);
		chk(rd & 32'h4, 32'h4);
		apb(1'h1, 8'h00, 32'h1);
		run(sw(4'he, 1, 1, 0, 0, 4'h5, 4'h3, 12'h0), 5'h13);
		chk({al, nacc_r - n0}, {1'h1, 8'h0});
		run(sm(0, 1, 0, 0, 4'h5, 16'h0001), 5'h13);
		chk({al, nacc_r - n0}, {1'h1, 8'h0});
		run(sw(4'he, 1, 1, 1, 0, 4'h5, 4'h3, 12'h0), 5'h13);
		chk({al, nacc_r - n0}, {1'h0, 8'h1});
		apb(1'h0, 8'h08, 32'h0);
		chk(rd, 32'h19);
		apb(1'h1, 8'h00, 32'h0);
		run(sm(0, 1, 1, 1, 4'h5, 16'h0001), 5'h10);
		end_of_test;
	end
endmodule : store_instruction_unit_bench
